// File: logic/dmwdt_pkg.sv
// Constants and register layout of the dual-mode watchdog
package dmwdt_pkg;
   // ---------------------------------------------------------------
   // Bus and register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFF_CONTROL = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_MASK = 4'h8;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int CTL_KEY_LSB = 16;
   localparam int CTL_ON_BIT = 15;
   localparam int CTL_RUNPS_LSB = 8;
   localparam int CTL_RCLK_LSB = 6;
   localparam int CTL_SLPPS_LSB = 1;
   localparam int CTL_WIN_BIT = 0;
   localparam logic [15:0] CLEAR_KEY = 16'h5743;
   localparam logic CTL_ON_RST = 1'b0;

   // ---------------------------------------------------------------
   // Configuration word fields
   // ---------------------------------------------------------------
   localparam int CFG_FUSE_EN_BIT = 15;
   localparam int CFG_WIN_BIT = 12;
   localparam int CFG_SLPPS_LSB = 7;
   localparam int CFG_RCLK_LSB = 5;
   localparam int CFG_RUNPS_LSB = 0;

   // ---------------------------------------------------------------
   // Status, sources, counting
   // ---------------------------------------------------------------
   localparam int ST_TIMEOUT = 0;
   localparam int ST_WAKE = 1;
   localparam int ST_EARLY = 2;
   localparam int ST_W = 3;
   localparam logic [ST_W-1:0] ST_RST = 3'h0;
   localparam logic [ST_W-1:0] MASK_RST = 3'h0;
   localparam int NUM_SRC = 4;
   localparam logic [1:0] LOW_POWER_RC_OSC_SRC = 2'h3;
   localparam int CNT_W = 32;
   localparam int WIN_SHIFT = 2;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0;

   typedef enum logic {DMWDT_RUN, DMWDT_SLEEP} dmwdt_mode_t;
endpackage : dmwdt_pkg

// File: logic/dmwdt_tick_if.sv
// Tick carrier between source synchroniser and watchdog core
`timescale 1ns/100ps
`default_nettype none
interface dmwdt_tick_if;
   logic [dmwdt_pkg::NUM_SRC-1:0] tick;
   modport src (output tick);
   modport snk (input tick);
endinterface : dmwdt_tick_if
`default_nettype wire

// File: logic/dmwdt_tick_sync.sv
// Synchronises counting clock sources and turns rising edges into ticks
`timescale 1ns/100ps
`default_nettype none
module dmwdt_tick_sync (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [dmwdt_pkg::NUM_SRC-1:0] src_clk_i,
   dmwdt_tick_if.src ticks
);
   import dmwdt_pkg::*;

   logic [NUM_SRC-1:0] meta_reg;
   logic [NUM_SRC-1:0] sync_reg;
   logic [NUM_SRC-1:0] last_reg;

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         // Sources are asynchronous; first stage feeds only the second
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
               last_reg[g] <= 1'b0;
            end else begin
               meta_reg[g] <= src_clk_i[g];
               sync_reg[g] <= meta_reg[g];
               last_reg[g] <= sync_reg[g];
            end
         end
         assign ticks.tick[g] = sync_reg[g] & ~last_reg[g];
      end
   endgenerate
endmodule : dmwdt_tick_sync
`default_nettype wire

// File: logic/dmwdt_top.sv
// Dual-mode watchdog with Avalon-MM register slave
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] A 16-bit write of 0x5743 to the upper half of control restarts the count.
// [RULE2] The clear-key field is write-only and reads as zero.
// [RULE3] Control bit 15 is a read/write enable of the watchdog.
// [RULE4] The software enable counts only while the fuse enable is zero.
// [RULE5] Control bits 14 and 13 read as zero.
// [RULE6] Bits 12 to 8 shadow the run postscale setting, loaded on every reset.
// [RULE7] Bits 7 to 6 shadow the run clock selection and pick the run counting source.
// [RULE8] Bits 5 to 1 shadow the sleep/idle postscale setting, loaded on reset.
// [RULE9] Bit 0 is the read/write window enable, loaded on reset from the config word.
// [RULE10] A time-out while enabled and running resets the device.
// [RULE11] A time-out during sleep or idle wakes the device instead.
// [RULE12] In sleep or idle the counter runs from the low-power RC oscillator.
// [RULE13] Run and sleep time-outs use their own postscale fields.
// [RULE14] Time-out occurs when the counter reaches two to the power of the postscale.
// [RULE15] In windowed mode a key write before the window opens resets the device.
module dmwdt_top (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [dmwdt_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [15:0] watchdog_config_word_i,
   input wire logic sleep_i,
   input wire logic [dmwdt_pkg::NUM_SRC-1:0] src_clk_i,
   output logic device_reset_o,
   output logic wake_o,
   output logic irq_o
);
   import dmwdt_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   dmwdt_tick_if tick_bus ();

   logic on_reg;
   logic on_next;
   logic [4:0] run_ps_reg;
   logic [1:0] run_clk_reg;
   logic [4:0] slp_ps_reg;
   logic win_reg;
   logic win_next;
   logic [ST_W-1:0] status_reg;
   logic [ST_W-1:0] status_next;
   logic [ST_W-1:0] mask_reg;
   logic [ST_W-1:0] mask_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   dmwdt_mode_t mode_reg;
   dmwdt_mode_t mode_next;
   logic ack_reg;
   logic ack_next;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rst_out_reg;
   logic wake_reg;
   logic irq_reg;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire req = avs_read_i | avs_write_i;
   // Writes land at the edge where waitrequest is seen low
   wire wr_go = avs_write_i & ack_reg;
   wire sel_ctl = (avs_address_i == OFF_CONTROL);
   wire sel_st = (avs_address_i == OFF_STATUS);
   wire sel_mask = (avs_address_i == OFF_MASK);
   wire wr_ctl = wr_go & sel_ctl;
   wire wr_st = wr_go & sel_st & avs_byteenable_i[0];
   wire wr_mask = wr_go & sel_mask & avs_byteenable_i[0];
   wire key_lanes = (avs_byteenable_i[3:2] == 2'b11);
   // [RULE1] exact key check
   wire key_ok = wr_ctl & key_lanes & (avs_writedata_i[31:CTL_KEY_LSB] == CLEAR_KEY);

   assign ack_next = req & ~ack_reg;

   // ---------------------------------------------------------------
   // Enable and counting selection
   // ---------------------------------------------------------------
   wire fuse_en = watchdog_config_word_i[CFG_FUSE_EN_BIT];
   // [RULE4] fuse overrides software enable
   wire active = fuse_en | on_reg;
   wire in_sleep = (mode_reg == DMWDT_SLEEP);
   // [RULE7] [RULE12] source choice per mode
   wire [1:0] src_sel = in_sleep ? LOW_POWER_RC_OSC_SRC : run_clk_reg;
   wire tick = tick_bus.tick[src_sel];
   // [RULE13] postscale per mode
   wire [4:0] ps_sel = in_sleep ? slp_ps_reg : run_ps_reg;
   // [RULE14] terminal count two to the power ps
   wire [CNT_W-1:0] term = CNT_ONE << ps_sel;
   wire [CNT_W-1:0] win_open = term - (term >> WIN_SHIFT);
   wire expire = active & tick & (cnt_reg >= term - CNT_ONE);
   // [RULE15] clear before window opens
   wire early = active & key_ok & win_reg & (cnt_reg < win_open);
   wire fault_run = ~in_sleep & (expire | early);
   wire wake_ev = in_sleep & expire;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // [RULE3] software enable bit
   assign on_next = (wr_ctl & avs_byteenable_i[1]) ? avs_writedata_i[CTL_ON_BIT] : on_reg;
   // [RULE9] window enable writable
   assign win_next = (wr_ctl & avs_byteenable_i[0]) ? avs_writedata_i[CTL_WIN_BIT] : win_reg;
   assign mask_next = wr_mask ? avs_writedata_i[ST_W-1:0] : mask_reg;
   assign mode_next = sleep_i ? DMWDT_SLEEP : DMWDT_RUN;

   // Events win over a same-cycle write-one clear
   wire [ST_W-1:0] st_set = {early & ~in_sleep, wake_ev, expire & ~in_sleep};
   wire [ST_W-1:0] st_clr = wr_st ? avs_writedata_i[ST_W-1:0] : {ST_W{1'b0}};
   assign status_next = (status_reg & ~st_clr) | st_set;

   // Mode change restarts the count so periods never mix
   always_comb begin
      cnt_next = cnt_reg;
      if (!active || key_ok || expire || early || (mode_next != mode_reg)) begin
         // [RULE1] restart on valid key
         cnt_next = CNT_RST;
      end else if (tick) begin
         cnt_next = cnt_reg + CNT_ONE;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // [RULE2] [RULE5] key reads zero, gap reads zero
   wire [31:0] ctl_rd = {16'h0000, on_reg, 2'b00, run_ps_reg, run_clk_reg, slp_ps_reg, win_reg};
   wire [31:0] st_rd = {{(32-ST_W){1'b0}}, status_reg};
   wire [31:0] mask_rd = {{(32-ST_W){1'b0}}, mask_reg};
   // Unmapped addresses read as zero and ignore writes
   assign rdata_next = sel_ctl ? ctl_rd : sel_st ? st_rd : sel_mask ? mask_rd : 32'h0;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         on_reg <= CTL_ON_RST;
         status_reg <= ST_RST;
         mask_reg <= MASK_RST;
         mode_reg <= DMWDT_RUN;
      end else begin
         on_reg <= on_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         mode_reg <= mode_next;
      end
   end

   // Shadow fields reload from the config word in every reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         // [RULE6] [RULE7] [RULE8] [RULE9] shadow load
         run_ps_reg <= watchdog_config_word_i[CFG_RUNPS_LSB +: 5];
         run_clk_reg <= watchdog_config_word_i[CFG_RCLK_LSB +: 2];
         slp_ps_reg <= watchdog_config_word_i[CFG_SLPPS_LSB +: 5];
         win_reg <= watchdog_config_word_i[CFG_WIN_BIT];
      end else begin
         win_reg <= win_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cnt_reg <= CNT_RST;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ack_reg <= 1'b0;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
      end else begin
         ack_reg <= ack_next;
         wait_reg <= ~ack_next;
         rdata_reg <= ack_next ? rdata_next : rdata_reg;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rst_out_reg <= 1'b0;
         wake_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         // [RULE10] [RULE15] device reset pulse
         rst_out_reg <= fault_run;
         // [RULE11] wake instead of reset
         wake_reg <= wake_ev;
         irq_reg <= |(status_next & mask_next);
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign device_reset_o = rst_out_reg;
   assign wake_o = wake_reg;
   assign irq_o = irq_reg;

   // ---------------------------------------------------------------
   // Source synchroniser
   // ---------------------------------------------------------------
   dmwdt_tick_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .src_clk_i(src_clk_i),
      .ticks(tick_bus.src)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   key_restart_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE1]
      key_ok && !early |=> cnt_reg == CNT_RST)
      else $error("counter not restarted by key");

   key_readzero_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE2]
      !avs_waitrequest_o && $past(sel_ctl) |-> avs_readdata_o[31:16] == 16'h0000)
      else $error("key field read nonzero");

   enable_write_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE3]
      wr_ctl && avs_byteenable_i[1] |=> on_reg == $past(avs_writedata_i[CTL_ON_BIT]))
      else $error("enable bit not written");

   disabled_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE4]
      !fuse_en && !on_reg |=> cnt_reg == CNT_RST ##1 !device_reset_o)
      else $error("disabled watchdog still counts");

   gap_zero_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE5]
      !avs_waitrequest_o && $past(sel_ctl) |-> avs_readdata_o[14:13] == 2'b00)
      else $error("unimplemented bits read nonzero");

   shadow_load_a: assert property (@(posedge clk_sys_i) // [RULE6]
      $fell(srst_i) |-> run_ps_reg == watchdog_config_word_i[CFG_RUNPS_LSB +: 5])
      else $error("run postscale not loaded");

   run_timeout_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE10]
      expire && !in_sleep |=> device_reset_o && !wake_o)
      else $error("run time-out did not reset");

   sleep_wake_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE11]
      expire && in_sleep |=> wake_o && !device_reset_o)
      else $error("sleep time-out did not wake");

   low_power_rc_osc_sleep_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE12]
      in_sleep && active && !tick_bus.tick[LOW_POWER_RC_OSC_SRC] && !key_ok |=> cnt_reg <= $past(cnt_reg))
      else $error("sleep count not on low-power source");

   early_fault_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE15]
      early && !in_sleep |=> device_reset_o && status_reg[ST_EARLY])
      else $error("early clear not faulted");

   shadow_clk_a: assert property (@(posedge clk_sys_i) // [RULE7]
      $fell(srst_i) |-> run_clk_reg == watchdog_config_word_i[CFG_RCLK_LSB +: 2])
      else $error("run clock select not loaded");

   shadow_sleep_a: assert property (@(posedge clk_sys_i) // [RULE8]
      $fell(srst_i) |-> slp_ps_reg == watchdog_config_word_i[CFG_SLPPS_LSB +: 5])
      else $error("sleep postscale not loaded");

   window_load_a: assert property (@(posedge clk_sys_i) // [RULE9]
      $fell(srst_i) |-> win_reg == watchdog_config_word_i[CFG_WIN_BIT])
      else $error("window enable not loaded");

   shadow_readonly_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE6]
      !srst_i |=> $stable(run_ps_reg) && $stable(run_clk_reg) && $stable(slp_ps_reg))
      else $error("shadow field changed outside reset");

   window_write_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE9]
      wr_ctl && avs_byteenable_i[0] |=> win_reg == $past(avs_writedata_i[CTL_WIN_BIT]))
      else $error("window enable not written");

   run_source_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE7]
      !in_sleep && active && !tick_bus.tick[run_clk_reg] |=> cnt_reg <= $past(cnt_reg))
      else $error("run count not on selected source");

   run_period_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE13]
      !in_sleep && active && tick_bus.tick[run_clk_reg]
         && cnt_reg == (CNT_ONE << run_ps_reg) - CNT_ONE |=> device_reset_o)
      else $error("run period not from run postscale");

   sleep_period_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE13]
      in_sleep && active && tick_bus.tick[LOW_POWER_RC_OSC_SRC]
         && cnt_reg == (CNT_ONE << slp_ps_reg) - CNT_ONE |=> wake_o)
      else $error("sleep period not from sleep postscale");

   early_count_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE14]
      active && !in_sleep && !key_ok
         && cnt_reg < (CNT_ONE << run_ps_reg) - CNT_ONE |=> !device_reset_o)
      else $error("reset before terminal count");

   // Status bits only drop through a write-one clear
   status_sticky_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !wr_st |=> (status_reg & $past(status_reg)) == $past(status_reg))
      else $error("status bit lost without clear");

   irq_level_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      irq_o == |(status_reg & mask_reg))
      else $error("interrupt level wrong");

   wait_single_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
endmodule : dmwdt_top
`default_nettype wire

// File: dv/test_dmwdt_top.sv
// Self-checking bench of the dual-mode watchdog
`timescale 1ns/100ps
`default_nettype none
module test_dmwdt_top;
   import dmwdt_pkg::*;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [ADDR_W-1:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [15:0] watchdog_config_word_i = 16'h0082;
   logic sleep_i = 1'b0;
   logic [NUM_SRC-1:0] src_clk_i = 4'h0;
   logic device_reset_o;
   logic wake_o;
   logic irq_o;
   logic [31:0] rd;
   int mismatches = 0;
   int total_checks = 0;
   int resets_seen = 0;
   int wakes_seen = 0;
   int exp_rst = 0;
   int exp_wake = 0;

   always #20 clk_sys_i = ~clk_sys_i;

   dmwdt_top dut (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .watchdog_config_word_i(watchdog_config_word_i), .sleep_i(sleep_i),
      .src_clk_i(src_clk_i), .device_reset_o(device_reset_o),
      .wake_o(wake_o), .irq_o(irq_o)
   );

   // Pulse tallies; one-cycle pulses are caught at every edge
   always @(posedge clk_sys_i) begin
      if (device_reset_o === 1'b1) resets_seen <= resets_seen + 1;
      if (wake_o === 1'b1) wakes_seen <= wakes_seen + 1;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Called just after a rising edge; holds the request until waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do begin
         @(posedge clk_sys_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // Idle edge so back-to-back calls never drive a strobe twice in one step
      @(posedge clk_sys_i);
      chk32("waitrequest after answer", 32'h1, {31'h0, avs_waitrequest_o});
   endtask

   // Source period of 8 system cycles, well above the synchroniser limit
   task automatic tick(input int src, input int n);
      repeat (n) begin
         src_clk_i[src] <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         src_clk_i[src] <= 1'b0;
         repeat (4) @(posedge clk_sys_i);
      end
   endtask

   task automatic pulses();
      chk32("device resets", exp_rst, resets_seen);
      chk32("wakes", exp_wake, wakes_seen);
   endtask

   task automatic do_reset(input logic [15:0] cfg);
      watchdog_config_word_i <= cfg;
      sleep_i <= 1'b0;
      srst_i <= 1'b1;
      repeat (12) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   function automatic logic [31:0] ctl(input logic [15:0] c, input logic on, input logic w);
      return {16'h0, on, 2'b00, c[4:0], c[6:5], c[11:7], w};
   endfunction

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_regs();
      bus(1'b0, OFF_CONTROL, 32'h0, 4'hf);
      chk32("control at reset", ctl(16'h0082, 1'b0, 1'b0), rd);
      bus(1'b0, 4'hc, 32'h0, 4'hf);
      chk32("unmapped read", 32'h0, rd);
      bus(1'b1, OFF_CONTROL, 32'hffff_ffff, 4'hf);
      bus(1'b0, OFF_CONTROL, 32'h0, 4'hf);
      chk32("control all ones", ctl(16'h0082, 1'b1, 1'b1), rd);
      bus(1'b1, OFF_CONTROL, 32'h0, 4'h3);
      bus(1'b0, OFF_CONTROL, 32'h0, 4'hf);
      chk32("control cleared", ctl(16'h0082, 1'b0, 1'b0), rd);
      $display("test regs done");
   endtask

   task automatic test_run();
      tick(0, 4);
      pulses();
      bus(1'b1, OFF_CONTROL, 32'h0000_8000, 4'h3);
      tick(0, 3);
      tick(3, 2);
      pulses();
      tick(0, 1);
      exp_rst++;
      pulses();
      tick(0, 3);
      bus(1'b1, OFF_CONTROL, {CLEAR_KEY, 16'h0}, 4'hc);
      tick(0, 3);
      pulses();
      tick(0, 1);
      exp_rst++;
      pulses();
      tick(0, 2);
      bus(1'b1, OFF_CONTROL, 32'h5742_0000, 4'hc);
      tick(0, 2);
      exp_rst++;
      pulses();
      bus(1'b0, OFF_STATUS, 32'h0, 4'hf);
      chk32("status", 32'h1, rd);
      chk32("irq masked", 32'h0, {31'h0, irq_o});
      bus(1'b1, OFF_MASK, 32'h1, 4'h1);
      repeat (2) @(posedge clk_sys_i);
      chk32("irq unmasked", 32'h1, {31'h0, irq_o});
      bus(1'b1, OFF_STATUS, 32'h1, 4'h1);
      repeat (2) @(posedge clk_sys_i);
      chk32("irq cleared", 32'h0, {31'h0, irq_o});
      $display("test run done");
   endtask

   task automatic test_sleep();
      sleep_i <= 1'b1;
      @(posedge clk_sys_i);
      tick(0, 4);
      tick(3, 1);
      pulses();
      tick(3, 1);
      exp_wake++;
      pulses();
      bus(1'b0, OFF_STATUS, 32'h0, 4'hf);
      chk32("status wake", 32'h2, rd);
      sleep_i <= 1'b0;
      @(posedge clk_sys_i);
      $display("test sleep done");
   endtask

   task automatic test_fuse();
      do_reset(16'h80a2);
      bus(1'b0, OFF_CONTROL, 32'h0, 4'hf);
      chk32("control fuse", ctl(16'h80a2, 1'b0, 1'b0), rd);
      tick(1, 4);
      exp_rst++;
      pulses();
      $display("test fuse done");
   endtask

   task automatic test_window();
      do_reset(16'h1082);
      bus(1'b0, OFF_CONTROL, 32'h0, 4'hf);
      chk32("control window", ctl(16'h1082, 1'b0, 1'b1), rd);
      bus(1'b1, OFF_CONTROL, 32'h0000_8001, 4'h3);
      bus(1'b1, OFF_CONTROL, {CLEAR_KEY, 16'h0}, 4'hc);
      repeat (2) @(posedge clk_sys_i);
      exp_rst++;
      pulses();
      bus(1'b0, OFF_STATUS, 32'h0, 4'hf);
      chk32("status early", 32'h4, rd);
      bus(1'b1, OFF_CONTROL, 32'h0000_8000, 4'h3);
      bus(1'b1, OFF_CONTROL, {CLEAR_KEY, 16'h0}, 4'hc);
      bus(1'b1, OFF_CONTROL, 32'h0000_8001, 4'h3);
      tick(0, 3);
      bus(1'b1, OFF_CONTROL, {CLEAR_KEY, 16'h0}, 4'hc);
      repeat (2) @(posedge clk_sys_i);
      pulses();
      $display("test window done");
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      do_reset(16'h0082);
      test_regs();
      test_run();
      test_sleep();
      test_fuse();
      test_window();
      print_verdict();
   end

   // Nearly eighty times the expected length of all scenarios
   initial begin
      repeat (30000) @(posedge clk_sys_i);
      mismatches++;
      $display("BAD run length expected end seen hang");
      print_verdict();
   end
endmodule // test_dmwdt_top
`default_nettype wire
